// [hdl/mps_defs.svh]
/*
  Constants of the multi-UE access-burst slot scheduler: period and frame times,
  slot and table sizes, markers and factory defaults.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef MPS_DEFS_SVH
`define MPS_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Times in nanoseconds
`define MPS_PERIOD_NS   32'h04C4_B400  // 80 ms scheduling period
`define MPS_FRAME_NS    32'h0098_9680  // 10 ms radio frame
`define MPS_CLK_NS      32'h0000_0019  // 25 ns clock period

////////////////////////////////////////////////////////////////////////////////
// Period structure and table sizes
`define MPS_NSLOTS      7'h3C          // Access slots per period
`define MPS_LAST_SLOT   6'h3B          // Highest slot number
`define MPS_NUE         8              // Simulated user equipments
`define MPS_NPOS        8              // Start positions per equipment
`define MPS_EMPTY_SLOT  6'h3F          // Unassigned start position
`define MPS_SLOT_W      6              // Width of a slot number
`define MPS_SIG_W       4              // Width of a signature number
`define MPS_CNT_W       22             // Width of cycle counters
`define MPS_CODE_W      16             // Control code index over data code index

////////////////////////////////////////////////////////////////////////////////
// Code tree and defaults
`define MPS_CTL_LEAF    4'hF           // Control code offset at spreading 256
`define MPS_SF_LOG_MAX  3'h4           // Data shift for the widest slot format
`define MPS_DEF_SIG     4'h0           // Default signature
`define MPS_DEF_FMT     2'h0           // Default slot format
`define MPS_DEF_SLOT    6'h00          // Default first start of equipment 1

`endif

// [hdl/mps_pkg.sv]
/*
  Types of the multi-UE access-burst slot scheduler.
  Assumes the constants header is on the include path.
*/
`include "mps_defs.svh"

package mps_pkg;

  // State of the scheduler core
  typedef struct packed {
    logic                                  start;      // Next cycle opens a period
    logic [`MPS_CNT_W-1:0]                 slot_cnt;   // Cycle within slot
    logic [5:0]                            frac;       // Slot length remainder
    logic [`MPS_SLOT_W-1:0]                slot_idx;   // Current access slot
    logic [`MPS_CNT_W-1:0]                 frame_cnt;  // Cycle within frame
    logic [`MPS_NUE-1:0][6:0]              busy;       // First free slot per UE
    logic [`MPS_NUE-1:0][6:0]              due;        // Message slot per UE
    logic [`MPS_NUE-1:0]                   pend;       // Message outstanding
    logic [`MPS_NUE-1:0]                   seen;       // Trigger caught
    logic [2:0]                            sync;       // Trigger synchroniser
    logic                                  long_p;     // Period marker
    logic                                  frame_p;    // Frame marker
    logic                                  pre_p;      // Preamble marker
    logic                                  msg_p;      // Message marker
    logic                                  burst_p;    // Burst marker
    logic [`MPS_NUE-1:0]                   pre_ue;     // UEs sending preamble
    logic [`MPS_NUE-1:0]                   msg_ue;     // UEs starting message
    logic [`MPS_SLOT_W-1:0]                slot_out;   // Slot number shown
  } mps_core_st_t;

  // State of one code mapper
  typedef struct packed {
    logic [`MPS_CODE_W-1:0] pair;  // Control index over data index
  } mps_code_st_t;

endpackage : mps_pkg

// [hdl/mps_code_map.sv]
/*
  Channel code mapper for one equipment: control and data code indices from
  the signature and the slot format.
  Assumes a synchronous active-low reset on clk.
*/
`include "mps_defs.svh"

module mps_code_map (
  input  wire logic                    clk,        // System clock
  input  wire logic                    rst_n,      // Synchronous reset, low
  input  wire logic [`MPS_SIG_W-1:0]   signature,  // Chosen signature
  input  wire logic [1:0]              slot_fmt,   // Data part slot format
  output logic [`MPS_CODE_W-1:0]       code_pair   // Control index, data index
);

  mps_pkg::mps_code_st_t st_r;
  mps_pkg::mps_code_st_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Code selection
  always_comb begin
    st_nxt = st_r;
    st_nxt.pair[15:8] = {signature, `MPS_CTL_LEAF};
    st_nxt.pair[7:0] = 8'({4'h0, signature} << (`MPS_SF_LOG_MAX - {1'b0, slot_fmt}));
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign code_pair = st_r.pair;

endmodule : mps_code_map

// [hdl/mps_sched.sv]
/*
  Multi-UE access-burst slot scheduler: 80 ms period of 60 access slots, eight
  equipments with eight start positions each, self-overlap suppression,
  message gating by an external trigger and marker pulses.
  Assumes a 40 MHz clock, synchronous active-low reset, configuration held
  steady by the surrounding logic, and an asynchronous trigger pin.
*/
// Behaviour
// - Period repeats every 80 ms as 60 numbered access slots.
// - Whole period always runs, busy or not.
// - Eight equipments, any number active together.
// - Eight start positions per equipment; empty marker sends nothing.
// - Equipment with all positions empty is off.
// - Start inside own earlier burst of the same period is suppressed.
// - Only sent bursts block later ones.
// - Different equipments never block each other.
// - Factory default: equipment 1 starts in slot zero, rest default.
// - Sixteen signatures select both channel codes.
// - Control part uses spreading factor 256.
// - Data spreading from slot format, code node from signature.
// - Preamble-only or preamble-plus-message operation.
// - Preamble-only bursts take exactly one slot.
// - Long-frame marker when frame number modulo 8 is zero.
// - Frame marker every 10 ms frame.
// - Marker at slot start of each preamble.
// - Marker at slot start of each message.
// - Burst marker at boundaries between burst repetitions.
// - Gated message sent only if the external trigger came after the preamble by its due slot, else dropped.
`include "mps_defs.svh"

module mps_sched #(
  parameter int PERIOD_CYC = `MPS_PERIOD_NS / `MPS_CLK_NS,  // Cycles per period
  parameter int FRAME_CYC  = `MPS_FRAME_NS / `MPS_CLK_NS,   // Cycles per frame
  parameter int SLOT_CYC   = PERIOD_CYC / int'(`MPS_NSLOTS), // Base cycles per slot
  parameter int SLOT_REM   = PERIOD_CYC % int'(`MPS_NSLOTS)  // Spare cycles per period
) (
  input  wire logic                                  clk,             // System clock
  input  wire logic                                  rst_n,           // Sync reset, low
  input  wire logic                                  run,             // Generate periods
  input  wire logic                                  factory_default, // Use default set
  input  wire logic                                  msg_mode,        // Send message part
  input  wire logic                                  aich_gate,       // Gate on trigger
  input  wire logic                                  aich_trig,       // Trigger pin
  input  wire logic [1:0]                            slot_format,     // Data slot format
  input  wire logic [3:0]                            tpm_slots,       // Preamble to msg
  input  wire logic [7:0]                            burst_len_half,  // Burst, half slots
  input  wire logic [`MPS_NUE*`MPS_SIG_W-1:0]        ue_signature,    // Per UE signature
  input  wire logic [`MPS_NUE*`MPS_NPOS*6-1:0]       ue_start,        // Start positions
  output logic [`MPS_SLOT_W-1:0]                     slot_num,        // Current slot
  output logic                                       long_frame_pulse,// Period marker
  output logic                                       frame_pulse,     // Frame marker
  output logic                                       preamble_pulse,  // Preamble marker
  output logic                                       message_pulse,   // Message marker
  output logic                                       burst_pulse,     // Burst marker
  output logic [`MPS_NUE-1:0]                        ue_preamble,     // Preamble per UE
  output logic [`MPS_NUE-1:0]                        ue_message,      // Message per UE
  output logic [`MPS_NUE*`MPS_CODE_W-1:0]            derived_channel_code_pair // Codes
);

  mps_pkg::mps_core_st_t st_r;
  mps_pkg::mps_core_st_t st_nxt;

  logic                       msg_eff;     // Message mode in force
  logic                       gate_eff;    // Trigger gating in force
  logic [1:0]                 fmt_eff;     // Slot format in force
  logic [6:0]                 len_slots;   // Burst length in whole slots
  logic [`MPS_NUE-1:0]        ue_off;      // Equipment has no start
  logic [`MPS_NUE*`MPS_NPOS*6-1:0] start_eff; // Start table in force

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration in force
  // Default set overrides inputs
  assign msg_eff  = factory_default ? 1'b0 : msg_mode;
  assign gate_eff = factory_default ? 1'b0 : aich_gate;
  assign fmt_eff  = factory_default ? `MPS_DEF_FMT : slot_format;

  assign len_slots = !msg_eff ? 7'h01 :
                     (burst_len_half < 8'h02) ? 7'h01 :
                     (burst_len_half >= 8'h80) ? `MPS_NSLOTS :  // Covers the whole period
                     7'((burst_len_half + 8'h01) >> 1);

  // Start table and off detection
  always_comb begin
    for (int u = 0; u < `MPS_NUE; u++) begin
      for (int p = 0; p < `MPS_NPOS; p++) begin
        if (factory_default) begin
          start_eff[(u*`MPS_NPOS+p)*6 +: 6] = (u == 0 && p == 0) ? `MPS_DEF_SLOT
                                                                  : `MPS_EMPTY_SLOT;
        end else begin
          start_eff[(u*`MPS_NPOS+p)*6 +: 6] = ue_start[(u*`MPS_NPOS+p)*6 +: 6];
        end
      end
    end
    for (int u = 0; u < `MPS_NUE; u++) begin
      ue_off[u] = 1'b1;
      for (int p = 0; p < `MPS_NPOS; p++) begin
        if (start_eff[(u*`MPS_NPOS+p)*6 +: 6] <= `MPS_LAST_SLOT) begin
          ue_off[u] = 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scheduler next state
  always_comb begin
    logic                       tick;
    logic                       hit_long;
    logic                       bnd;
    logic                       per;
    logic [`MPS_SLOT_W-1:0]     ns;
    logic [6:0]                 busy_eff;
    logic                       hit;
    logic                       rise;
    tick     = 1'b0;
    hit_long = 1'b0;
    bnd      = 1'b0;
    per      = 1'b0;
    ns       = '0;
    busy_eff = '0;
    hit      = 1'b0;
    rise     = 1'b0;
    st_nxt   = st_r;
    // Trigger pin through three flops, edge on the later pair
    st_nxt.sync = {st_r.sync[1:0], aich_trig};
    rise        = st_r.sync[1] & ~st_r.sync[2];
    // Markers last one cycle
    st_nxt.long_p  = 1'b0;
    st_nxt.frame_p = 1'b0;
    st_nxt.pre_p   = 1'b0;
    st_nxt.msg_p   = 1'b0;
    st_nxt.burst_p = 1'b0;
    st_nxt.pre_ue  = '0;
    st_nxt.msg_ue  = '0;
    if (!run) begin
      st_nxt.start     = 1'b1;
      st_nxt.slot_cnt  = '0;
      st_nxt.frame_cnt = '0;
      st_nxt.frac      = '0;
    end else begin
      hit_long = (7'({1'b0, st_r.frac}) + 7'(SLOT_REM)) >= `MPS_NSLOTS;
      tick     = hit_long ? (st_r.slot_cnt == `MPS_CNT_W'(SLOT_CYC))
                          : (st_r.slot_cnt == `MPS_CNT_W'(SLOT_CYC - 1));
      bnd      = st_r.start | tick;
      // Period always wraps after last slot
      per      = st_r.start | (tick && st_r.slot_idx == `MPS_LAST_SLOT);
      // Counter back to zero each period
      ns       = per ? '0 : st_r.slot_idx + 6'h01;
      if (per || st_r.frame_cnt == `MPS_CNT_W'(FRAME_CYC - 1)) begin
        st_nxt.frame_cnt = '0;
        st_nxt.frame_p   = 1'b1;
      end else begin
        st_nxt.frame_cnt = st_r.frame_cnt + `MPS_CNT_W'(1);
      end
      // Period start is frame number 0 mod 8
      st_nxt.long_p = per;
      st_nxt.start  = 1'b0;
      if (!bnd) begin
        st_nxt.slot_cnt = st_r.slot_cnt + `MPS_CNT_W'(1);
      end else begin
        st_nxt.slot_cnt = '0;
        st_nxt.slot_idx = ns;
        st_nxt.slot_out = ns;
        if (per) begin
          st_nxt.frac = '0;
        end else if (hit_long) begin
          st_nxt.frac = 6'(7'({1'b0, st_r.frac}) + 7'(SLOT_REM) - `MPS_NSLOTS);
        end else begin
          st_nxt.frac = 6'(7'({1'b0, st_r.frac}) + 7'(SLOT_REM));
        end
        if (per) begin
          st_nxt.pend = '0;
        end
        // Each equipment scheduled on its own
        for (int u = 0; u < `MPS_NUE; u++) begin
          // Message start at its due slot
          if (!per && st_r.pend[u] && st_r.due[u] == {1'b0, ns}) begin
            st_nxt.pend[u] = 1'b0;
            // Sent if gating is off or the trigger came by the due slot, else dropped
            if (!gate_eff || st_r.seen[u] || rise) begin
              st_nxt.msg_ue[u] = 1'b1;
              st_nxt.msg_p     = 1'b1;
            end
          end
          // Any assigned position matching the slot
          hit = 1'b0;
          for (int p = 0; p < `MPS_NPOS; p++) begin
            if (start_eff[(u*`MPS_NPOS+p)*6 +: 6] == ns) begin
              hit = 1'b1;
            end
          end
          busy_eff = per ? 7'h00 : st_r.busy[u];
          if (hit && !ue_off[u] && {1'b0, ns} >= busy_eff) begin
            // Only sent bursts set the busy mark
            st_nxt.busy[u]   = {1'b0, ns} + len_slots;
            st_nxt.pre_ue[u] = 1'b1;
            st_nxt.pre_p     = 1'b1;
            st_nxt.burst_p   = 1'b1;
            // Message follows only in message mode
            if (msg_eff) begin
              st_nxt.pend[u] = 1'b1;
              st_nxt.due[u]  = {1'b0, ns} + {3'h0, tpm_slots};
              st_nxt.seen[u] = 1'b0;
            end
          end else if (per) begin
            st_nxt.busy[u] = '0;
          end
        end
      end
      for (int u = 0; u < `MPS_NUE; u++) begin
        if (rise && st_nxt.pend[u]) begin
          st_nxt.seen[u] = 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r       <= '0;
      st_r.start <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign slot_num         = st_r.slot_out;
  assign long_frame_pulse = st_r.long_p;
  assign frame_pulse      = st_r.frame_p;
  assign preamble_pulse   = st_r.pre_p;
  assign message_pulse    = st_r.msg_p;
  assign burst_pulse      = st_r.burst_p;
  assign ue_preamble      = st_r.pre_ue;
  assign ue_message       = st_r.msg_ue;

  ////////////////////////////////////////////////////////////////////////////////
  // Channel codes per equipment
  // Codes follow the signature
  for (genvar g = 0; g < `MPS_NUE; g++) begin : g_code
    mps_code_map u_code (
      .clk       (clk),
      .rst_n     (rst_n),
      .signature (factory_default ? `MPS_DEF_SIG : ue_signature[g*`MPS_SIG_W +: `MPS_SIG_W]),
      .slot_fmt  (fmt_eff),
      .code_pair (derived_channel_code_pair[g*`MPS_CODE_W +: `MPS_CODE_W])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_slot_range: assert property (slot_num <= `MPS_LAST_SLOT)
    else $error("slot number beyond last slot");

  a_period_zero: assert property (long_frame_pulse |-> slot_num == '0)
    else $error("period marker away from slot zero");

  a_long_frame: assert property (long_frame_pulse |-> frame_pulse)
    else $error("period marker without frame marker");

  a_wrap_after_last: assert property (
    (run && st_r.slot_idx == `MPS_LAST_SLOT) ##1 (st_r.slot_idx != `MPS_LAST_SLOT)
    |-> st_r.slot_idx == '0 && long_frame_pulse)
    else $error("period did not wrap after last slot");

  a_pre_marker: assert property (preamble_pulse == (|ue_preamble))
    else $error("preamble marker disagrees with equipments");

  a_msg_marker: assert property (message_pulse == (|ue_message))
    else $error("message marker disagrees with equipments");

  a_burst_marker: assert property (burst_pulse |-> preamble_pulse)
    else $error("burst marker without preamble");

  a_preonly_quiet: assert property ((!msg_eff)[*2] |-> ue_message == '0)
    else $error("message sent in preamble-only mode");

  a_off_silent: assert property ($past(ue_off[7]) |-> !ue_preamble[7])
    else $error("switched-off equipment sent a preamble");

  a_self_block: assert property (
    ue_preamble[0] && slot_num != '0 |-> {1'b0, slot_num} >= $past(st_r.busy[0]))
    else $error("preamble inside own earlier burst");

  a_aich_hold: assert property (
    $past(gate_eff) |-> ((ue_message & ~$past(st_r.seen)) == '0) ||
    $past(st_r.sync[1]))
    else $error("gated message sent without trigger");

  a_slot_step: assert property ($changed(slot_num) |->
    slot_num == $past(slot_num) + 6'h01 || slot_num == '0)
    else $error("slot number skipped a step");

  a_pre_at_start: assert property (preamble_pulse |-> st_r.slot_cnt == '0)
    else $error("preamble marker away from slot start");

  a_pre_single: assert property (preamble_pulse |=> !preamble_pulse)
    else $error("preamble marker longer than one cycle");

  a_msg_at_start: assert property (message_pulse |-> st_r.slot_cnt == '0)
    else $error("message marker away from slot start");

  a_frame_single: assert property (frame_pulse |=> !frame_pulse)
    else $error("frame marker longer than one cycle");

  a_long_single: assert property (long_frame_pulse |=> !long_frame_pulse)
    else $error("period marker longer than one cycle");

  a_default_first: assert property (
    $past(factory_default) && long_frame_pulse |-> ue_preamble == 8'h01)
    else $error("default set did not start equipment 1 in slot zero");

  a_preonly_len: assert property (
    !$past(msg_eff) && ue_preamble[3] |-> st_r.busy[3] == {1'b0, slot_num} + 7'h01)
    else $error("preamble-only burst longer than one slot");

  a_ctl_leaf: assert property (
    $past(rst_n) |-> derived_channel_code_pair[`MPS_CODE_W/2 +: `MPS_SIG_W] == `MPS_CTL_LEAF)
    else $error("control code not at spreading 256 leaf");

  a_code_sig: assert property (
    $past(rst_n) && !$past(factory_default) |->
    derived_channel_code_pair[`MPS_CODE_W-1 -: `MPS_SIG_W] == $past(ue_signature[`MPS_SIG_W-1:0]))
    else $error("control code does not follow signature");

endmodule : mps_sched

// [verification/mps_bts_model.sv]
/*
  Receiver model on the far side: answers each preamble with a trigger pulse.
  Assumes outputs of the scheduler settle before the falling clock edge.
*/
module mps_bts_model #(
  parameter int ANS_DLY = 5  // Cycles from preamble to trigger
) (
  input  wire logic       clk,          // System clock
  input  wire logic       answer_en,    // Answer preambles
  input  wire logic [7:0] ue_preamble,  // Preamble starts per UE
  output logic            aich_trig     // Trigger line, idle low
);
  timeunit 1ns;
  timeprecision 1ps;

  initial aich_trig = 1'b0;

  always @(negedge clk) begin
    if (answer_en && (ue_preamble != 8'h00)) begin
      repeat (ANS_DLY) @(negedge clk);
      aich_trig <= 1'b1;
      repeat (2) @(negedge clk);
      aich_trig <= 1'b0;
    end
  end
endmodule : mps_bts_model

// [verification/tb_top.sv]
/*
  Self-checking bench of the slot scheduler: default set, overlap
  suppression, preamble-only bursts with codes, trigger-gated messages.
  Assumes the scheduler built with a shortened period of 1200 cycles.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PER = 1200;          // Cycles per period
  localparam int WD  = 12 * PER * 25; // Watchdog span, ns

  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         run = 1'b0;
  logic         factory_default = 1'b0;
  logic         msg_mode = 1'b0;
  logic         aich_gate = 1'b0;
  logic         aich_trig;
  logic         answer_en = 1'b0;
  logic [1:0]   slot_format = 2'h0;
  logic [3:0]   tpm_slots = 4'h3;
  logic [7:0]   burst_len_half = 8'h02;
  logic [31:0]  ue_signature = 32'h0000_0000;
  logic [383:0] ue_start = '1;
  logic [5:0]   slot_num;
  logic         long_frame_pulse, frame_pulse, preamble_pulse;
  logic         message_pulse, burst_pulse;
  logic [7:0]   ue_preamble, ue_message;
  logic [127:0] derived_channel_code_pair;
  logic [7:0]   pre_log [64], msg_log [64], exp_pre [64], exp_msg [64];
  logic         rec = 1'b0;
  int           n_long, n_frame, n_pre, n_msg, n_burst;
  int           compares = 0;
  int           miscompares = 0;

  always #12.5 clk = ~clk;

  mps_sched #(.PERIOD_CYC(PER), .FRAME_CYC(150), .SLOT_CYC(20), .SLOT_REM(0)) i_mps_sched (
    .clk(clk), .rst_n(rst_n), .run(run), .factory_default(factory_default),
    .msg_mode(msg_mode), .aich_gate(aich_gate), .aich_trig(aich_trig),
    .slot_format(slot_format), .tpm_slots(tpm_slots), .burst_len_half(burst_len_half),
    .ue_signature(ue_signature), .ue_start(ue_start), .slot_num(slot_num),
    .long_frame_pulse(long_frame_pulse), .frame_pulse(frame_pulse),
    .preamble_pulse(preamble_pulse), .message_pulse(message_pulse),
    .burst_pulse(burst_pulse), .ue_preamble(ue_preamble), .ue_message(ue_message),
    .derived_channel_code_pair(derived_channel_code_pair));

  mps_bts_model i_mps_bts_model (
    .clk(clk), .answer_en(answer_en), .ue_preamble(ue_preamble), .aich_trig(aich_trig));

  ////////////////////////////////////////////////////////////////////////////
  // Slot log of starts and marker counts
  always @(negedge clk) begin
    if (rec) begin
      pre_log[slot_num] = pre_log[slot_num] | ue_preamble;
      msg_log[slot_num] = msg_log[slot_num] | ue_message;
      n_long  += int'(long_frame_pulse);
      n_frame += int'(frame_pulse);
      n_pre   += int'(preamble_pulse);
      n_msg   += int'(message_pulse);
      n_burst += int'(burst_pulse);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and helpers
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic set_pos(input int u, input int p, input logic [5:0] sl);
    ue_start[(8*u+p)*6 +: 6] = sl;
  endtask : set_pos

  // Reset for two cycles, clear logs and expectations
  task automatic prep;
    @(negedge clk);
    rst_n = 1'b0;
    run = 1'b0;
    factory_default = 1'b0;
    msg_mode = 1'b0;
    aich_gate = 1'b0;
    answer_en = 1'b0;
    burst_len_half = 8'h02;
    ue_start = '1;
    for (int s = 0; s < 64; s++) begin
      pre_log[s] = 8'h00;
      msg_log[s] = 8'h00;
      exp_pre[s] = 8'h00;
      exp_msg[s] = 8'h00;
    end
    {n_long, n_frame, n_pre, n_msg, n_burst} = '0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
  endtask : prep

  task automatic run_periods(input int n);
    rec = 1'b1;
    run = 1'b1;
    repeat (n * PER) @(negedge clk);
    run = 1'b0;
    @(posedge clk);
    rec = 1'b0;
  endtask : run_periods

  task automatic cmp_logs;
    for (int s = 0; s < 64; s++) begin
      chk(pre_log[s], exp_pre[s]);
      chk(msg_log[s], exp_msg[s]);
    end
  endtask : cmp_logs

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_default;
    prep();
    factory_default = 1'b1;
    exp_pre[0] = 8'h01;
    run_periods(2);
    cmp_logs();
    chk(n_long, 2);
    chk(n_frame, 16);
    chk(n_pre, 2);
    chk(n_burst, 2);
    chk(derived_channel_code_pair[15:0], 16'h0F00);
    $display("test default done");
  endtask : t_default

  task automatic t_overlap;
    prep();
    msg_mode = 1'b1;
    burst_len_half = 8'h17;
    set_pos(0, 0, 6'h00);
    set_pos(0, 1, 6'h06);
    set_pos(0, 2, 6'h0C);
    set_pos(1, 0, 6'h06);
    set_pos(1, 1, 6'h3A);
    {exp_pre[0], exp_pre[6], exp_pre[12], exp_pre[58]} = 32'h0102_0102;
    {exp_msg[3], exp_msg[9], exp_msg[15]} = 24'h01_0201;
    run_periods(1);
    cmp_logs();
    chk(n_msg, 3);
    $display("test overlap done");
  endtask : t_overlap

  task automatic t_preonly;
    logic [3:0]  sg;
    logic [15:0] ex;
    prep();
    burst_len_half = 8'h17;
    for (int u = 0; u < 8; u++) begin
      ue_signature[4*u +: 4] = 4'(2*u+1);
    end
    for (int p = 0; p < 8; p++) begin
      set_pos(3, p, 6'(p));
      exp_pre[p] = 8'h08;
    end
    run_periods(1);
    cmp_logs();
    for (int f = 0; f < 4; f++) begin
      @(negedge clk);
      slot_format = 2'(f);
      repeat (2) @(negedge clk);
      for (int u = 0; u < 8; u++) begin
        sg = 4'(2*u+1);
        ex = {sg, 4'hF, 8'({4'h0, sg} << (4-f))};
        chk(derived_channel_code_pair[16*u +: 16], ex);
      end
    end
    $display("test preamble only done");
  endtask : t_preonly

  task automatic t_gate(input logic en);
    prep();
    msg_mode = 1'b1;
    aich_gate = 1'b1;
    answer_en = en;
    set_pos(2, 0, 6'h05);
    set_pos(2, 1, 6'h14);
    exp_pre[5] = 8'h04;
    exp_pre[20] = 8'h04;
    exp_msg[8] = en ? 8'h04 : 8'h00;
    exp_msg[23] = en ? 8'h04 : 8'h00;
    run_periods(1);
    cmp_logs();
    $display("test gate %0d done", en);
  endtask : t_gate

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    t_default();
    t_overlap();
    t_preonly();
    t_gate(1'b1);
    t_gate(1'b0);
    report_and_stop();
  end

  // Watchdog against a hang
  initial begin
    #(WD);
    miscompares++;
    report_and_stop();
  end
endmodule : tb_top
